// ---- rtl/pswsq_core.sv ----
// instruction address and condition code keeping with branch evaluation
// assumes fetch, alu and register writes come from logic on clk_sys_i
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - next fetch address held in bits 40-63
// - status word kept internal, never addressable
// - each fetch advances address by its length
// - one-halfword instruction adds two bytes
// - op bits 0-1 pick 2/4/6; 11 gives 6
// - op bits 01 or 10 add four
// - taken branch overwrites sequential address with target
// - two-bit condition code in bits 34-35
// - code changes only on code-setting instructions
// - add/subtract: zero, negative, positive, overflow
// - code held until next code-setting instruction
// - compare gives equal/low/high, never 11
// - branch on condition in both formats
// - mask bits 8-11 map codes 0-3 leftwise
// - branch when mask bit of code set
// - mask 0000 never branches, except on the unconditional kind, which ignores the mask
// - mask 1111 always branches
`include "pswsq_defs.svh"
module pswsq_core
    import pswsq_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic fetch_i,
    input wire logic [7:0] fetch_opcode_i,
    input wire logic cc_update_i,
    input wire pswsq_ccsrc_e cc_src_i,
    input wire logic arith_zero_i,
    input wire logic arith_neg_i,
    input wire logic arith_ovf_i,
    input wire logic cmp_equal_i,
    input wire logic cmp_low_i,
    input wire logic branch_i,
    input wire pswsq_br_e branch_kind_i,
    input wire logic [3:0] branch_mask_field_i,
    input wire logic [3:0] target_register_field_i,
    input wire logic [`PSWSQ_IA_W-1:0] branch_addr_i,
    input wire logic greg_wr_i,
    input wire logic [3:0] greg_wr_addr_i,
    input wire logic [`PSWSQ_IA_W-1:0] greg_wr_data_i,
    output logic [`PSWSQ_IA_W-1:0] instr_addr_o,
    output logic [1:0] cond_code_o,
    output logic branch_taken_o,
    output logic busy_o
);
    function automatic logic [`PSWSQ_IA_W-1:0] len_incr(input logic [1:0] opb);
        if (opb == `PSWSQ_LEN_ONE) begin
            len_incr = `PSWSQ_INC_HALF;
        end else if (opb == `PSWSQ_LEN_SS) begin
            len_incr = `PSWSQ_INC_THREE;
        end else begin
            len_incr = `PSWSQ_INC_TWO;
        end
    endfunction

    function automatic logic mask_hit(input logic [3:0] m, input logic [1:0] cc);
        mask_hit = m[2'h3 - cc];
    endfunction

    // status word lives only here
    logic [`PSWSQ_PSW_W-1:0] program_status_word_r;
    logic [`PSWSQ_PSW_W-1:0] program_status_word_nxt;
    logic rr_pend_r;
    logic [3:0] rr_mask_r;
    logic [`PSWSQ_IA_W-1:0] greg_rd_data;
    wire logic [`PSWSQ_IA_W-1:0] ia_cur;
    wire logic [1:0] cc_cur;
    wire logic [`PSWSQ_IA_W-1:0] ia_seq;
    wire logic [1:0] arith_cc;
    wire logic [1:0] cmp_cc;
    wire logic [1:0] cc_new;
    wire logic cc_load;
    wire logic rx_take;
    wire logic rr_start;
    wire logic rr_take;
    wire logic [`PSWSQ_IA_W-1:0] ia_new;

    assign ia_cur = program_status_word_r[`PSWSQ_IA_MSB:`PSWSQ_IA_LSB];
    assign cc_cur = program_status_word_r[`PSWSQ_CC_MSB:`PSWSQ_CC_LSB];
    assign ia_seq = fetch_i ? ia_cur + len_incr(fetch_opcode_i[7:6]) : ia_cur;
    assign arith_cc = arith_ovf_i ? `PSWSQ_CC_OVF :
                      arith_zero_i ? `PSWSQ_CC_ZERO :
                      arith_neg_i ? `PSWSQ_CC_NEG : `PSWSQ_CC_POS;
    assign cmp_cc = cmp_equal_i ? `PSWSQ_CC_EQ :
                    cmp_low_i ? `PSWSQ_CC_LOW : `PSWSQ_CC_HIGH;
    assign cc_load = cc_update_i && (cc_src_i != PSWSQ_CC_NONE);
    assign cc_new = (cc_src_i == PSWSQ_CC_COMPARE) ? cmp_cc : arith_cc;
    assign rx_take = branch_i && !rr_pend_r &&
                     ((branch_kind_i == PSWSQ_BR_UNCOND) ||
                      ((branch_kind_i == PSWSQ_BR_COND_RX) &&
                       mask_hit(branch_mask_field_i, cc_cur)));
    assign rr_start = branch_i && !rr_pend_r && (branch_kind_i == PSWSQ_BR_COND_RR);
    assign rr_take = rr_pend_r && mask_hit(rr_mask_r, cc_cur);
    // target replaces sequential value, untaken keeps it
    assign ia_new = rr_take ? greg_rd_data : (rx_take ? branch_addr_i : ia_seq);

    always_comb begin
        program_status_word_nxt = program_status_word_r;
        program_status_word_nxt[`PSWSQ_IA_MSB:`PSWSQ_IA_LSB] = ia_new;
        if (cc_load) begin
            program_status_word_nxt[`PSWSQ_CC_MSB:`PSWSQ_CC_LSB] = cc_new;
        end
    end

    pswsq_greg_mem u_greg (
        .clk_sys_i(clk_sys_i),
        .wr_en_i(greg_wr_i),
        .wr_addr_i(greg_wr_addr_i),
        .wr_data_i(greg_wr_data_i),
        .rd_addr_i(target_register_field_i),
        .rd_data_o(greg_rd_data)
    );

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            program_status_word_r <= {`PSWSQ_PSW_W{1'b0}};
            rr_pend_r <= 1'b0;
            rr_mask_r <= 4'h0;
        end else begin
            program_status_word_r <= program_status_word_nxt;
            rr_pend_r <= rr_start;
            rr_mask_r <= branch_mask_field_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            instr_addr_o <= `PSWSQ_IA_RESET;
            cond_code_o <= `PSWSQ_CC_RESET;
            branch_taken_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            instr_addr_o <= ia_new;
            cond_code_o <= program_status_word_nxt[`PSWSQ_CC_MSB:`PSWSQ_CC_LSB];
            branch_taken_o <= rx_take || rr_take;
            busy_o <= rr_start;
        end
    end

    // sequential advance by length
    ss_advance_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fetch_i && fetch_opcode_i[7:6] == 2'b11 && !branch_i && !rr_pend_r
        |=> instr_addr_o == $past(ia_cur) + 24'h000006)
        else $error("six byte advance wrong");
    rr_advance_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fetch_i && fetch_opcode_i[7:6] == 2'b00 && !branch_i && !rr_pend_r
        |=> instr_addr_o == $past(ia_cur) + 24'h000002)
        else $error("two byte advance wrong");
    mid_advance_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        fetch_i && (fetch_opcode_i[7:6] == 2'b01 || fetch_opcode_i[7:6] == 2'b10)
        && !branch_i && !rr_pend_r
        |=> instr_addr_o == $past(ia_cur) + 24'h000004)
        else $error("four byte advance wrong");
    rx_target_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'hF
        |=> branch_taken_o && instr_addr_o == $past(branch_addr_i))
        else $error("full mask did not branch");
    nop_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'h0 |=> !branch_taken_o)
        else $error("empty mask branched");
    cc_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !cc_update_i |=> cond_code_o == $past(cc_cur))
        else $error("condition code changed");
    cmp_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_COMPARE |=> cond_code_o != 2'h3)
        else $error("compare gave code three");
    ovf_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_ARITH && arith_ovf_i
        |=> cond_code_o == 2'h3)
        else $error("overflow code wrong");
    rr_branch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rr_start |=> busy_o ##1 (branch_taken_o == $past(rr_take)))
        else $error("register branch sequence wrong");

    // address sequencing and override

    addr_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !fetch_i && !branch_i && !rr_pend_r
        |=> instr_addr_o == $past(ia_cur))
        else $error("address moved without fetch");

    uncond_take_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_UNCOND
        |=> branch_taken_o && instr_addr_o == $past(branch_addr_i))
        else $error("unconditional branch wrong");

    fetch_over_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && fetch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'hF |=> instr_addr_o == $past(branch_addr_i))
        else $error("target did not replace advance");

    rx_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX && !fetch_i
        && branch_mask_field_i == 4'h0 |=> instr_addr_o == $past(ia_cur))
        else $error("untaken branch moved address");

    rx_fetch_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX && fetch_i
        && fetch_opcode_i[7:6] == 2'h0 && branch_mask_field_i == 4'h0 |=> instr_addr_o == $past(ia_cur) + 24'h000002)
        else $error("untaken branch lost advance");

    // condition code settings

    zero_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_ARITH && !arith_ovf_i && arith_zero_i
        |=> cond_code_o == 2'h0)
        else $error("zero code wrong");

    neg_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_ARITH && !arith_ovf_i && !arith_zero_i
        && arith_neg_i |=> cond_code_o == 2'h1)
        else $error("negative code wrong");

    pos_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_ARITH && !arith_ovf_i && !arith_zero_i
        && !arith_neg_i |=> cond_code_o == 2'h2)
        else $error("positive code wrong");

    src3_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && arith_ovf_i && cc_src_i != PSWSQ_CC_NONE
        && cc_src_i != PSWSQ_CC_ARITH && cc_src_i != PSWSQ_CC_COMPARE |=> cond_code_o == 2'h3)
        else $error("source three code wrong");

    eq_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_COMPARE && cmp_equal_i
        |=> cond_code_o == 2'h0)
        else $error("equal code wrong");

    low_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_COMPARE && !cmp_equal_i && cmp_low_i
        |=> cond_code_o == 2'h1)
        else $error("low code wrong");

    high_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_COMPARE && !cmp_equal_i && !cmp_low_i
        |=> cond_code_o == 2'h2)
        else $error("high code wrong");

    none_code_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        cc_update_i && cc_src_i == PSWSQ_CC_NONE
        |=> cond_code_o == $past(cc_cur))
        else $error("code changed without source");

    code_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(cond_code_o)
        |-> $past(cc_update_i))
        else $error("code changed without update");

    // mask evaluation

    code0_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'h8 |=> branch_taken_o == ($past(cc_cur) == 2'h0))
        else $error("mask for code zero wrong");

    code1_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'h4 |=> branch_taken_o == ($past(cc_cur) == 2'h1))
        else $error("mask for code one wrong");

    code2_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'h2 |=> branch_taken_o == ($past(cc_cur) == 2'h2))
        else $error("mask for code two wrong");

    code3_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX
        && branch_mask_field_i == 4'h1 |=> branch_taken_o == ($past(cc_cur) == 2'h3))
        else $error("mask for code three wrong");

    pair_mask_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        branch_i && !rr_pend_r && branch_kind_i == PSWSQ_BR_COND_RX && branch_mask_field_i == 4'hA
        |=> branch_taken_o == ($past(cc_cur) == 2'h0 || $past(cc_cur) == 2'h2))
        else $error("two bit mask wrong");

    // register form and pulses

    rr_nop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rr_pend_r && rr_mask_r == 4'h0
        |=> !branch_taken_o)
        else $error("empty register mask branched");

    rr_full_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rr_pend_r && rr_mask_r == 4'hF
        |=> branch_taken_o && instr_addr_o == $past(greg_rd_data))
        else $error("full register mask did not branch");

    rr_keep_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        rr_pend_r && rr_mask_r == 4'h0 && !fetch_i
        |=> instr_addr_o == $past(ia_cur))
        else $error("untaken register branch moved address");

    busy_pulse_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        busy_o
        |=> !busy_o)
        else $error("busy longer than one cycle");

    idle_branch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !branch_i && !rr_pend_r
        |=> !branch_taken_o)
        else $error("branch without request");
endmodule
`default_nettype wire

// ---- rtl/pswsq_defs.svh ----
// constants for the status word sequencing and branch condition block
// assumes inclusion by bare name from the package and the main module
`ifndef PSWSQ_DEFS_SVH
`define PSWSQ_DEFS_SVH
`define PSWSQ_IA_W 24
`define PSWSQ_IA_LSB 40
`define PSWSQ_IA_MSB 63
`define PSWSQ_CC_LSB 34
`define PSWSQ_CC_MSB 35
`define PSWSQ_PSW_W 64
`define PSWSQ_IA_RESET 24'h000000
`define PSWSQ_CC_RESET 2'h0
`define PSWSQ_INC_HALF 24'h000002
`define PSWSQ_INC_TWO 24'h000004
`define PSWSQ_INC_THREE 24'h000006
`define PSWSQ_LEN_ONE 2'h0
`define PSWSQ_LEN_SS 2'h3
`define PSWSQ_CC_ZERO 2'h0
`define PSWSQ_CC_NEG 2'h1
`define PSWSQ_CC_POS 2'h2
`define PSWSQ_CC_OVF 2'h3
`define PSWSQ_CC_EQ 2'h0
`define PSWSQ_CC_LOW 2'h1
`define PSWSQ_CC_HIGH 2'h2
`define PSWSQ_MASK_NONE 4'h0
`define PSWSQ_MASK_ALL 4'hF
`define PSWSQ_NUM_GREGS 16
`define PSWSQ_GREG_AW 4
`endif

// ---- rtl/pswsq_pkg.sv ----
// types for the status word sequencing and branch condition block
// assumes the defs header is on the include path
`include "pswsq_defs.svh"
package pswsq_pkg;
    typedef enum logic [1:0] {
        PSWSQ_CC_NONE = 2'b00,
        PSWSQ_CC_ARITH = 2'b01,
        PSWSQ_CC_COMPARE = 2'b10
    } pswsq_ccsrc_e;
    typedef enum logic [1:0] {
        PSWSQ_BR_NONE = 2'b00,
        PSWSQ_BR_COND_RR = 2'b01,
        PSWSQ_BR_COND_RX = 2'b10,
        PSWSQ_BR_UNCOND = 2'b11
    } pswsq_br_e;
endpackage

// ---- rtl/pswsq_greg_mem.sv ----
// general register copy, sixteen words of 24 address bits
// assumes writes from the execution path on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "pswsq_defs.svh"
module pswsq_greg_mem (
    input wire logic clk_sys_i,
    input wire logic wr_en_i,
    input wire logic [`PSWSQ_GREG_AW-1:0] wr_addr_i,
    input wire logic [`PSWSQ_IA_W-1:0] wr_data_i,
    input wire logic [`PSWSQ_GREG_AW-1:0] rd_addr_i,
    output logic [`PSWSQ_IA_W-1:0] rd_data_o
);
    logic [`PSWSQ_IA_W-1:0] mem_r [0:`PSWSQ_NUM_GREGS-1];
    always_ff @(posedge clk_sys_i) begin
        if (wr_en_i) begin
            mem_r[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule
`default_nettype wire

// ---- test/pswsq_fetch_model.sv ----
// fetch path model: supplies the op code stored at the fetch address
// assumes the address comes straight from the block's instruction address
`timescale 1ns/100ps
`default_nettype none
module pswsq_fetch_model (
    input wire logic [23:0] addr_i,
    output logic [7:0] opcode_o
);
    // length bits vary with address so that all four length codes turn up
    assign opcode_o = {addr_i[2:1] + addr_i[4:3], 6'h05};
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// self-checking bench for the sequencing and branch condition block
// assumes the design package, defs header and fetch model are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench
    import pswsq_pkg::*;
;
    logic clk_sys_i = 0, reset_i = 1, fetch_i = 0, cc_update_i = 0, branch_i = 0, greg_wr_i = 0;
    logic [4:0] flags = 0;
    pswsq_ccsrc_e cc_src_i = PSWSQ_CC_NONE;
    pswsq_br_e branch_kind_i = PSWSQ_BR_NONE;
    logic [3:0] mask = 0, rfield = 0, greg_wr_addr_i = 0;
    logic [23:0] branch_addr_i = 0, greg_wr_data_i = 0, exp_ia = 0;
    logic [2:0] af [4] = '{3'b010, 3'b001, 3'b000, 3'b100};
    wire logic [7:0] opcode;
    wire logic [23:0] ia;
    wire logic [1:0] cc;
    wire logic taken, busy;
    logic seen;
    int num_errors = 0, total_checks = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    pswsq_fetch_model i_model (.addr_i(ia), .opcode_o(opcode));
    pswsq_core i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .fetch_i(fetch_i),
        .fetch_opcode_i(opcode), .cc_update_i(cc_update_i), .cc_src_i(cc_src_i),
        .arith_zero_i(flags[3]), .arith_neg_i(flags[2]), .arith_ovf_i(flags[4]),
        .cmp_equal_i(flags[1]), .cmp_low_i(flags[0]), .branch_i(branch_i),
        .branch_kind_i(branch_kind_i), .branch_mask_field_i(mask),
        .target_register_field_i(rfield), .branch_addr_i(branch_addr_i),
        .greg_wr_i(greg_wr_i), .greg_wr_addr_i(greg_wr_addr_i),
        .greg_wr_data_i(greg_wr_data_i), .instr_addr_o(ia), .cond_code_o(cc),
        .branch_taken_o(taken), .busy_o(busy));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [23:0] len_of(input logic [1:0] b);
        len_of = (b == 2'h0) ? 24'h000002 : (b == 2'h3) ? 24'h000006 : 24'h000004;
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic fetch();
        logic [23:0] inc;
        inc = len_of(opcode[7:6]);
        fetch_i = 1;
        cyc(1);
        fetch_i = 0;
        cyc(2);
        exp_ia = exp_ia + inc;
        chk(ia, exp_ia);
    endtask
    task automatic setcc(input pswsq_ccsrc_e s, input logic [4:0] f, input logic [1:0] exp);
        flags = f;
        cc_src_i = s;
        cc_update_i = 1;
        cyc(1);
        cc_update_i = 0;
        cyc(2);
        chk({22'h0, cc}, {22'h0, exp});
    endtask
    task automatic br(input pswsq_br_e k, input logic [3:0] m, input logic [3:0] r,
        input logic [23:0] a, input logic f, input logic ex, input logic [23:0] tgt);
        logic [23:0] inc;
        inc = len_of(opcode[7:6]);
        branch_kind_i = k;
        mask = m;
        rfield = r;
        branch_addr_i = a;
        fetch_i = f;
        branch_i = 1;
        cyc(1);
        branch_i = 0;
        fetch_i = 0;
        chk({23'h0, busy}, {23'h0, k == PSWSQ_BR_COND_RR});
        seen = taken;
        repeat (3) begin
            cyc(1);
            seen = seen | taken;
        end
        exp_ia = ex ? tgt : (f ? exp_ia + inc : exp_ia);
        chk({23'h0, seen}, {23'h0, ex});
        chk(ia, exp_ia);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        cyc(3);
        reset_i = 0;
        chk(ia, 24'h0);
        chk({22'h0, cc}, 24'h0);
        $display("test reset done");
        repeat (8) fetch();
        $display("test fetch done");
        for (int i = 0; i < 4; i++) begin
            setcc(PSWSQ_CC_ARITH, {af[i], 2'b00}, i[1:0]);
        end
        setcc(pswsq_ccsrc_e'(2'h3), 5'b10000, 2'b11);
        setcc(PSWSQ_CC_COMPARE, 5'b00010, 2'b00);
        setcc(PSWSQ_CC_COMPARE, 5'b00001, 2'b01);
        setcc(PSWSQ_CC_COMPARE, 5'b10100, 2'b10);
        setcc(PSWSQ_CC_NONE, 5'b01000, 2'b10);
        fetch();
        chk({22'h0, cc}, 24'h000002);
        $display("test condition code done");
        for (int c = 0; c < 4; c++) begin
            setcc(PSWSQ_CC_ARITH, {af[c], 2'b00}, c[1:0]);
            for (int m = 0; m < 16; m++) begin
                br(PSWSQ_BR_COND_RX, m[3:0], 4'h0, {16'h0012, m[3:0], c[1:0], 2'b00},
                    m[0], m[3 - c], {16'h0012, m[3:0], c[1:0], 2'b00});
            end
        end
        $display("test mask done");
        greg_wr_addr_i = 4'h9;
        greg_wr_data_i = 24'h00ABC4;
        greg_wr_i = 1;
        cyc(1);
        greg_wr_i = 0;
        setcc(PSWSQ_CC_COMPARE, 5'b00001, 2'b01);
        br(PSWSQ_BR_COND_RR, 4'h8, 4'h9, 24'h0, 1'b0, 1'b0, 24'h0);
        br(PSWSQ_BR_COND_RR, 4'h4, 4'h9, 24'h0, 1'b1, 1'b1, 24'h00ABC4);
        br(PSWSQ_BR_COND_RR, 4'h0, 4'h9, 24'h0, 1'b0, 1'b0, 24'h0);
        br(PSWSQ_BR_COND_RR, 4'hF, 4'h9, 24'h0, 1'b0, 1'b1, 24'h00ABC4);
        br(PSWSQ_BR_UNCOND, 4'h0, 4'h0, 24'h003456, 1'b1, 1'b1, 24'h003456);
        $display("test register branch done");
        conclude();
    end
    initial begin
        repeat (100000) @(posedge clk_sys_i);
        num_errors++;
        conclude();
    end
endmodule
`default_nettype wire
